/* File: ipc_defs.svh */
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH
`define IPC_PMC_ADDR 8'h87
`define IPC_BIT_BAUD 7
`define IPC_BIT_FLAG_HI 3
`define IPC_BIT_FLAG_LO 2
`define IPC_BIT_PDN_REQ 1
`define IPC_BIT_IDLE_REQ 0
`define IPC_RESET_VAL 8'h00
`define IPC_RSV_MASK 8'h70
`define IPC_OSC_PER_MC 12
`define IPC_RST_MC 2
`define IPC_PULLUP_CYC 2
`endif

/* File: ipc_pkg.sv */
package ipc_pkg;
    typedef enum logic [1:0] {
        IPC_NORMAL = 2'b00,
        IPC_IDLE = 2'b01,
        IPC_PDOWN = 2'b10
    } ipc_mode_e;
    // one sfr bus access from the cpu core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ipc_sfr_s;
    // port latch and external-bus view supplied by the core
    typedef struct packed {
        logic [7:0] port0_latch;
        logic [7:0] port1_latch;
        logic [7:0] port_two_latch;
        logic [7:0] port3_latch;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] data_out;
        logic ext_access;
        logic addr_phase;
        logic ale_norm;
        logic fetch_norm;
    } ipc_port_s;
endpackage : ipc_pkg

/* File: ipc_power_ctrl.sv */
`timescale 1ns/10ps
`include "ipc_defs.svh"
// Function
// [RULE1] power_mode_control sits at sfr address 87h, byte access only
// [RULE2] baud_double set doubles serial baud in modes 1, 2, 3
// [RULE3] two user flags at bits 3 and 2, free read/write, no effect
// [RULE4] writing powerdown_request one enters power down mode
// [RULE5] writing idle_request one enters idle mode
// [RULE6] both request bits in one write: power down wins
// [RULE7] reset clears bit 7 and bits 3..0
// [RULE8] idle gates only the cpu clock; peripherals keep clock
// [RULE9] idle keeps all cpu state unchanged
// [RULE10] enabled interrupt in idle clears idle_request and restarts cpu
// [RULE11] after interrupt return, code resumes after idle-setting instruction
// [RULE12] reset ends idle; two machine cycles suffice
// [RULE13] power down stops oscillator; only ram kept
// [RULE14] only reset leaves power down; interrupts do not
// [RULE15] external reset held until oscillator is stable
// [RULE16] idle: strobes high, ports hold data, external: port 0 floats
// [RULE17] power down: strobes low, port 0 floats if external, port 2 latch
// [RULE18] latch 0-to-1 gives strong pullup for two oscillator periods
// [RULE19] port two address ones keep strong pullup during access
// [RULE20] port 0 open drain: latch one floats
// [RULE21] port 0 on external bus drives address/data ones strongly
// [RULE22] program verification needs external port 0 pullups
// [RULE23] reset high two machine cycles resets the device
// [RULE24] reserved bits ignore writes, read undefined (zero here)
module ipc_power_ctrl #(
    parameter int RST_CYC = `IPC_RST_MC * `IPC_OSC_PER_MC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire ipc_pkg::ipc_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic irq_pending,
    input wire ipc_pkg::ipc_port_s port,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_run,
    output logic baud_double,
    output logic core_reset,
    output ipc_pkg::ipc_mode_e mode,
    output logic ale,
    output logic program_fetch_strobe,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe,
    output logic [7:0] port1_out,
    output logic [7:0] port2_out,
    output logic [7:0] port3_out,
    output logic [7:0] port1_strong,
    output logic [7:0] port2_strong,
    output logic [7:0] port3_strong
);
    import ipc_pkg::*;

    // the history shifter below needs at least two bits
    if (RST_CYC < 3) begin : g_bad_rst
        $error("RST_CYC must be at least three");
    end

    logic [7:0] pmc_q;
    ipc_mode_e mode_q;
    logic rst_meta_q;
    logic rst_sync_q;
    logic [RST_CYC-2:0] rst_hist_q;
    logic core_reset_q;
    logic pmc_wr;
    logic [7:0] pt1_prev_q, pt2_prev_q, pt3_prev_q;
    logic [7:0] pt1_pulse_q, pt2_pulse_q, pt3_pulse_q;
    logic [7:0] pt1_pulse2_q, pt2_pulse2_q, pt3_pulse2_q;
    logic [7:0] pt0_q, pt0_oe_q, pt1_q, pt2_q, pt3_q;
    logic ale_q, fetch_q;
    logic [7:0] pt2_drive;

    // byte-wide decode only; there is no bit-address path into this register
    assign pmc_wr = sfr.wr && (sfr.addr == `IPC_PMC_ADDR); // RULE1

    // reset pin comes from outside the clock domain: two flops first
    always_ff @(posedge mclk) begin
        rst_meta_q <= srst;
        rst_sync_q <= rst_meta_q;
    end

    // history of synchronised reset samples; a shifter needs no reset of its
    // own, so it settles to ones after enough high samples even from power-up
    always_ff @(posedge mclk) begin
        rst_hist_q <= {rst_hist_q[RST_CYC-3:0], rst_sync_q};
    end

    // core reset only after RST_CYC high samples in a row, so short glitches
    // cannot end idle; it drops at the first low sample
    always_ff @(posedge mclk) begin
        core_reset_q <= rst_sync_q && (&rst_hist_q); // RULE23 RULE12
    end

    // power control register; powerdown masks idle when both are written
    always_ff @(posedge mclk) begin
        if (core_reset_q) begin
            pmc_q <= `IPC_RESET_VAL; // RULE7
        end else if (pmc_wr && mode_q == IPC_NORMAL) begin
            pmc_q[`IPC_BIT_BAUD] <= sfr.wdata[`IPC_BIT_BAUD]; // RULE2
            pmc_q[`IPC_BIT_FLAG_HI] <= sfr.wdata[`IPC_BIT_FLAG_HI]; // RULE3
            pmc_q[`IPC_BIT_FLAG_LO] <= sfr.wdata[`IPC_BIT_FLAG_LO]; // RULE3
            pmc_q[`IPC_BIT_PDN_REQ] <= sfr.wdata[`IPC_BIT_PDN_REQ]; // RULE4
            pmc_q[`IPC_BIT_IDLE_REQ] <= sfr.wdata[`IPC_BIT_IDLE_REQ]
                                        & ~sfr.wdata[`IPC_BIT_PDN_REQ]; // RULE6
            pmc_q[6:4] <= 3'h0; // RULE24
        end else if (mode_q == IPC_IDLE && irq_pending) begin
            // hardware clear of the idle request; flags are left for software
            pmc_q[`IPC_BIT_IDLE_REQ] <= 1'b0; // RULE10
        end
    end

    // mode machine; only reset leaves power down
    always_ff @(posedge mclk) begin
        if (core_reset_q) begin
            mode_q <= IPC_NORMAL; // RULE12
        end else begin
            case (mode_q)
                IPC_NORMAL: begin
                    if (pmc_wr && sfr.wdata[`IPC_BIT_PDN_REQ]) begin
                        mode_q <= IPC_PDOWN; // RULE4 RULE6
                    end else if (pmc_wr && sfr.wdata[`IPC_BIT_IDLE_REQ]) begin
                        mode_q <= IPC_IDLE; // RULE5
                    end
                end
                IPC_IDLE: begin
                    if (irq_pending) begin
                        mode_q <= IPC_NORMAL; // RULE10 RULE11
                    end
                end
                IPC_PDOWN: mode_q <= IPC_PDOWN; // RULE14
                default: mode_q <= IPC_NORMAL;
            endcase
        end
    end

    // clock gating: cpu state simply freezes, so it is kept across idle
    assign cpu_clk_en = (mode_q == IPC_NORMAL); // RULE8 RULE9
    // timers, serial port and interrupt logic keep running in idle
    assign periph_clk_en = (mode_q != IPC_PDOWN); // RULE8
    // the oscillator restarts as soon as a full reset is seen
    assign osc_run = (mode_q != IPC_PDOWN) || core_reset_q; // RULE13 RULE15
    assign baud_double = pmc_q[`IPC_BIT_BAUD]; // RULE2
    assign core_reset = core_reset_q;
    assign mode = mode_q;

    // read path is combinational so the core sees data in the access cycle
    assign sfr_hit = sfr.rd && (sfr.addr == `IPC_PMC_ADDR); // RULE1
    assign sfr_rdata = sfr_hit ? (pmc_q & ~`IPC_RSV_MASK) : 8'h00; // RULE24

    // strong pullup pulse: two cycles after a latch rises; the previous value
    // resets to ones so the release of reset gives no false rising edge
    always_ff @(posedge mclk) begin
        if (core_reset_q) begin
            pt1_prev_q <= 8'hff;
            pt2_prev_q <= 8'hff;
            pt3_prev_q <= 8'hff;
            pt1_pulse_q <= 8'h00;
            pt2_pulse_q <= 8'h00;
            pt3_pulse_q <= 8'h00;
            pt1_pulse2_q <= 8'h00;
            pt2_pulse2_q <= 8'h00;
            pt3_pulse2_q <= 8'h00;
        end else begin
            pt1_prev_q <= pt1_q;
            pt2_prev_q <= pt2_drive;
            pt3_prev_q <= pt3_q;
            pt1_pulse_q <= pt1_q & ~pt1_prev_q; // RULE18
            pt2_pulse_q <= pt2_drive & ~pt2_prev_q; // RULE18
            pt3_pulse_q <= pt3_q & ~pt3_prev_q; // RULE18
            pt1_pulse2_q <= pt1_pulse_q;
            pt2_pulse2_q <= pt2_pulse_q;
            pt3_pulse2_q <= pt3_pulse_q;
        end
    end

    // port 2 shows address only while executing externally and not powered down
    assign pt2_drive = (port.ext_access && mode_q != IPC_PDOWN) ? port.addr_hi
                                                                 : port.port_two_latch;

    // pin state per mode, registered
    always_ff @(posedge mclk) begin
        if (core_reset_q) begin
            ale_q <= 1'b1;
            fetch_q <= 1'b1;
            pt0_q <= 8'hff;
            pt0_oe_q <= 8'h00;
            pt1_q <= 8'hff;
            pt2_q <= 8'hff;
            pt3_q <= 8'hff;
        end else begin
            pt1_q <= port.port1_latch;
            pt3_q <= port.port3_latch;
            pt2_q <= pt2_drive; // RULE16 RULE17
            case (mode_q)
                IPC_IDLE: begin
                    ale_q <= 1'b1; // RULE16
                    fetch_q <= 1'b1; // RULE16
                end
                IPC_PDOWN: begin
                    ale_q <= 1'b0; // RULE17
                    fetch_q <= 1'b0; // RULE17
                end
                default: begin
                    ale_q <= port.ale_norm;
                    fetch_q <= port.fetch_norm;
                end
            endcase
            if (port.ext_access) begin
                // bus mode drives both levels; floats in low power
                pt0_q <= port.addr_phase ? port.addr_lo : port.data_out; // RULE21
                pt0_oe_q <= (mode_q == IPC_NORMAL) ? 8'hff : 8'h00; // RULE16 RULE17
            end else begin
                // open drain: only zeros are driven, ones float
                pt0_q <= 8'h00;
                pt0_oe_q <= ~port.port0_latch; // RULE20
            end
        end
    end

    // pin outputs from the registers; port 2 strong pullup also depends on ext_access and mode
    assign ale = ale_q;
    assign program_fetch_strobe = fetch_q;
    assign port0_out = pt0_q;
    assign port0_oe = pt0_oe_q;
    assign port1_out = pt1_q;
    assign port2_out = pt2_q;
    assign port3_out = pt3_q;
    assign port1_strong = pt1_pulse_q | pt1_pulse2_q; // RULE18
    // address ones hold the strong pullup for the whole access
    assign port2_strong = (port.ext_access && mode_q == IPC_NORMAL) ? pt2_q // RULE19
                                                                    : (pt2_pulse_q | pt2_pulse2_q);
    assign port3_strong = pt3_pulse_q | pt3_pulse2_q; // RULE18

    // checks on the register, the mode machine, the clock enables, the power-down strobes and the port 1 pullup pulse
    pd_wins_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE6
        mode_q == IPC_NORMAL && pmc_wr && sfr.wdata[`IPC_BIT_PDN_REQ]
        |=> mode_q == IPC_PDOWN)
        else $error("power down did not win");
    idle_enter_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE5
        mode_q == IPC_NORMAL && pmc_wr && sfr.wdata[1:0] == 2'b01 |=> !cpu_clk_en)
        else $error("idle not entered");
    idle_wake_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE10
        mode_q == IPC_IDLE && irq_pending |=> cpu_clk_en && !pmc_q[`IPC_BIT_IDLE_REQ])
        else $error("idle wake failed");
    idle_hold_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE9
        mode_q == IPC_IDLE && pmc_wr && !irq_pending |=> pmc_q == $past(pmc_q))
        else $error("register changed in idle");
    flag_write_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE3
        mode_q == IPC_NORMAL && pmc_wr
        |=> pmc_q[3:2] == $past(sfr.wdata[3:2]) && baud_double == $past(sfr.wdata[7]))
        else $error("flag or baud write lost");
    rsv_read_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE24
        sfr_hit |-> sfr_rdata[6:4] == 3'h0)
        else $error("reserved bits read nonzero");
    pd_stay_a: assert property (@(posedge mclk) disable iff (srst) // RULE14
        mode_q == IPC_PDOWN |=> mode_q == IPC_PDOWN)
        else $error("left power down without reset");
    periph_clk_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE8
        mode_q == IPC_IDLE |-> periph_clk_en && osc_run)
        else $error("peripheral clock lost in idle");
    strobes_pd_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE17
        mode_q == IPC_PDOWN ##1 mode_q == IPC_PDOWN |-> !ale && !program_fetch_strobe)
        else $error("strobes not low in power down");
    pullup_len_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE18
        $rose(pt1_q[0]) |=> port1_strong[0] [*2] ##1 !port1_strong[0])
        else $error("pullup pulse length wrong");
    rst_clear_a: assert property (@(posedge mclk) // RULE7
        core_reset_q |=> pmc_q == 8'h00 && mode_q == IPC_NORMAL)
        else $error("reset did not clear");

    // checks on the pins in the low-power modes
    port0_float_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE16
        port.ext_access && mode_q != IPC_NORMAL |=> port0_oe == 8'h00)
        else $error("port 0 driven in low power");
    port2_pd_a: assert property (@(posedge mclk) disable iff (core_reset_q) // RULE17
        mode_q == IPC_PDOWN |=> port2_out == $past(port.port_two_latch))
        else $error("port 2 not latch in power down");

    // main scenarios
    cov_idle_c: cover property (@(posedge mclk) mode_q == IPC_IDLE ##1 mode_q == IPC_NORMAL);
    cov_pd_c: cover property (@(posedge mclk) mode_q == IPC_PDOWN);
    cov_both_c: cover property (@(posedge mclk) pmc_wr && sfr.wdata[1:0] == 2'b11);
    cov_ext_idle_c: cover property (@(posedge mclk) port.ext_access && mode_q == IPC_IDLE);
endmodule : ipc_power_ctrl

/* File: ipc_ext_mem.sv */
`timescale 1ns/10ps
// external memory on the pin side: resolves port 0 and latches the bus address
module ipc_ext_mem (
    input wire logic mclk,
    input wire logic ale,
    input wire logic [7:0] port0_out,
    input wire logic [7:0] port0_oe,
    input wire logic [7:0] port2_out,
    output logic [15:0] addr_q,
    output logic [7:0] port0_wire
);
    // board pullups on port 0, so a released pin reads high, never a stale value
    assign port0_wire = (port0_oe & port0_out) | ~port0_oe;
    // address captured while the latch strobe is high
    always_ff @(posedge mclk) begin
        if (ale) begin
            addr_q <= {port2_out, port0_wire};
        end
    end
endmodule : ipc_ext_mem

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
    import ipc_pkg::*;
    localparam int RST_N = 8; // shorter than the 16-cycle start reset, so it takes
    logic mclk, srst, irq_pending, sfr_hit, cpu_clk_en, periph_clk_en, osc_run;
    logic baud_double, core_reset, ale, fstrobe;
    logic [7:0] sfr_rdata, port0_out, port0_oe, port1_out, port2_out, port3_out, port0_wire, v;
    logic [7:0] port1_strong, port2_strong, port3_strong;
    logic [15:0] mem_addr;
    ipc_sfr_s sfr;
    ipc_port_s port;
    ipc_mode_e mode;
    int err_total, n_compared, k, hits, hits3;
    ipc_power_ctrl #(.RST_CYC(RST_N)) i_dut (.mclk(mclk), .srst(srst), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .irq_pending(irq_pending), .port(port),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
        .baud_double(baud_double), .core_reset(core_reset), .mode(mode), .ale(ale),
        .program_fetch_strobe(fstrobe), .port0_out(port0_out), .port0_oe(port0_oe),
        .port1_out(port1_out), .port2_out(port2_out), .port3_out(port3_out),
        .port1_strong(port1_strong), .port2_strong(port2_strong),
        .port3_strong(port3_strong));
    ipc_ext_mem i_mem (.mclk(mclk), .ale(ale), .port0_out(port0_out), .port0_oe(port0_oe),
        .port2_out(port2_out), .addr_q(mem_addr), .port0_wire(port0_wire));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    // one write, held for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr.wr = 1'b1;
        sfr.addr = a;
        sfr.wdata = d;
        cyc(1);
        sfr.wr = 1'b0;
        cyc(1);
    endtask : wr
    // read held across one sampling edge, data taken while it still stands
    task automatic rdc(input logic [7:0] a, input logic [7:0] d, input logic h);
        sfr.rd = 1'b1;
        sfr.addr = a;
        cyc(1);
        chk("rdata", sfr_rdata, d);
        chk("hit", {7'h0, sfr_hit}, {7'h0, h});
        sfr.rd = 1'b0;
        cyc(1);
    endtask : rdc
    task automatic chm(input ipc_mode_e m);
        chk("mode", {6'h0, mode}, {6'h0, m});
    endtask : chm
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // watchdog well beyond the two hundred or so cycles the sequence needs
    initial begin
        #300000;
        err_total++;
        test_done;
    end
    initial begin
        srst = 1'b1;
        irq_pending = 1'b0;
        sfr = '0;
        port = '0;
        err_total = 0;
        n_compared = 0;
        v = 8'($urandom(32'hbacce6d6));
        cyc(16);
        srst = 1'b0;
        cyc(3);
        chk("core_reset", {7'h0, core_reset}, 8'h00);
        rdc(8'h87, 8'h00, 1'b1);
        rdc(8'h86, 8'h00, 1'b0);
        // random bytes with both request bits clear, first one the all-ones corner
        for (k = 0; k < 12; k++) begin
            v = (k == 0) ? 8'hfc : 8'($urandom) & 8'hfc;
            wr(8'h87, v);
            rdc(8'h87, v & 8'h8c, 1'b1);
            chk("baud", {7'h0, baud_double}, {7'h0, v[7]});
            wr(8'h85, ~v);
            rdc(8'h87, v & 8'h8c, 1'b1);
        end
        wr(8'h87, 8'h05);
        chm(IPC_IDLE);
        chk("clk", {6'h0, cpu_clk_en, periph_clk_en}, 8'h01);
        chk("strobes", {6'h0, ale, fstrobe}, 8'h03);
        wr(8'h87, 8'h80);
        rdc(8'h87, 8'h05, 1'b1);
        irq_pending = 1'b1;
        for (k = 0; k < 10 && mode == IPC_IDLE; k++) begin
            cyc(1);
        end
        irq_pending = 1'b0;
        chm(IPC_NORMAL);
        rdc(8'h87, 8'h04, 1'b1);
        wr(8'h87, 8'h01);
        srst = 1'b1;
        cyc(RST_N + 4);
        srst = 1'b0;
        cyc(3);
        chm(IPC_NORMAL);
        wr(8'h87, 8'h03);
        chm(IPC_PDOWN);
        chk("clk", {5'h0, cpu_clk_en, periph_clk_en, osc_run}, 8'h00);
        chk("strobes", {6'h0, ale, fstrobe}, 8'h00);
        irq_pending = 1'b1;
        cyc(5);
        irq_pending = 1'b0;
        chm(IPC_PDOWN);
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        cyc(3);
        chm(IPC_PDOWN);
        // reset held past the count so the oscillator has settled before release
        srst = 1'b1;
        cyc(RST_N + 6);
        chk("osc_run", {7'h0, osc_run}, 8'h01);
        srst = 1'b0;
        cyc(3);
        chm(IPC_NORMAL);
        port.port1_latch = 8'h00;
        port.port3_latch = 8'h00;
        cyc(4);
        port.port1_latch = 8'hff;
        port.port3_latch = 8'hff;
        hits = 0;
        hits3 = 0;
        for (k = 0; k < 8; k++) begin
            cyc(1);
            hits += (port1_strong === 8'hff);
            hits3 += (port3_strong === 8'hff);
        end
        chk("pulse1", 8'(hits), 8'h02);
        chk("pulse3", 8'(hits3), 8'h02);
        chk("port3", port3_out, 8'hff);
        v = 8'($urandom);
        port.port0_latch = v;
        cyc(3);
        chk("port0_wire", port0_wire, v);
        port.ext_access = 1'b1;
        port.ale_norm = 1'b1;
        port.addr_phase = 1'b1;
        port.addr_lo = 8'($urandom);
        port.addr_hi = 8'($urandom);
        port.port_two_latch = ~port.addr_hi;
        cyc(3);
        chk("port2", port2_out, port.addr_hi);
        chk("port2_strong", port2_strong, port.addr_hi);
        chk("port0", port0_out, port.addr_lo);
        chk("port0_oe", port0_oe, 8'hff);
        chk("mem_lo", mem_addr[7:0], port.addr_lo);
        chk("mem_hi", mem_addr[15:8], port.addr_hi);
        wr(8'h87, 8'h01);
        cyc(2);
        chk("port0_oe", port0_oe, 8'h00);
        chk("port2", port2_out, port.addr_hi);
        chk("strobes", {6'h0, ale, fstrobe}, 8'h03);
        irq_pending = 1'b1;
        cyc(2);
        irq_pending = 1'b0;
        chm(IPC_NORMAL);
        wr(8'h87, 8'h02);
        cyc(2);
        chk("port2", port2_out, port.port_two_latch);
        chk("port0_oe", port0_oe, 8'h00);
        test_done;
    end
endmodule : testbench
